// >>> include/emar_pkg.sv
// Purpose: shared constants and types of the energy meter alert registers
// Assumes: byte-wide register space reached over a two-wire serial port
// Notes: multi-byte counters sit most significant byte at the lowest address
package emar_pkg;
    localparam logic [7:0] OFS_MASK_DS = 8'h19;
    localparam logic [7:0] OFS_MASK_DIFF = 8'h1A;
    localparam logic [7:0] OFS_ENERGY = 8'h7A;
    localparam logic [7:0] OFS_TICK = 8'h80;
    localparam logic [7:0] OFS_METER_CTL = 8'h84;
    localparam logic [7:0] OFS_SNAPSHOT = 8'h85;
    localparam int ENERGY_BYTES = 6;
    localparam int TICK_BYTES = 4;
    localparam int CNT_BYTES = ENERGY_BYTES + TICK_BYTES;
    localparam int MC_RESET = 7;
    localparam int MC_HALT = 6;
    localparam int MC_TICK_OVF = 5;
    localparam int MC_ENERGY_OVF = 4;
    localparam int MC_ALERT = 3;
    localparam int SNAP_MODE = 3;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [47:0] ENERGY_RST = 48'h0;
    localparam logic [31:0] TICK_RST = 32'h0;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // auxiliary input codes run in this order from 0000 to 1111
    typedef enum logic [3:0] {
        SEL_ANALOG_1, SEL_ANALOG_2, SEL_ANALOG_3, SEL_ANALOG_4,
        SEL_BIDIR_1, SEL_BIDIR_2, SEL_BIDIR_3, SEL_BIDIR_4,
        SEL_DRAIN_SOURCE, SEL_DRAIN, SEL_SHUNT_1, SEL_SHUNT_2,
        SEL_ANALOG_PAIR_2_1, SEL_ANALOG_PAIR_4_3,
        SEL_BIDIR_PAIR_2_1, SEL_BIDIR_PAIR_4_3
    } emar_snap_sel_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } emar_wr_s;

    typedef struct packed {
        emar_snap_sel_e sel;
        logic single;
    } emar_snap_s;
endpackage : emar_pkg

// >>> hdl/emar_meter.sv
// Purpose: energy accumulator and tick counter
// Assumes: conv_done is a one-cycle pulse from same-clock logic
// Notes: a host byte write wins over a conversion in the same cycle
module emar_meter
    import emar_pkg::*;
#(
    parameter int PW = 24
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic halt,
    input wire logic conv_done,
    input wire logic [PW-1:0] power,
    input wire logic wr,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    output logic [ENERGY_BYTES*8-1:0] energy,
    output logic [TICK_BYTES*8-1:0] ticks,
    output logic energy_evt,
    output logic tick_evt
);
    localparam int EW = ENERGY_BYTES * 8;
    localparam int TW = TICK_BYTES * 8;
    logic [EW-1:0] next_energy;
    logic [TW-1:0] next_ticks;
    logic next_energy_evt;
    logic next_tick_evt;
    logic [EW+TW-1:0] flat;

    // clear beats write, write beats accumulation
    always_comb
    begin
        next_energy = energy;
        next_ticks = ticks;
        next_energy_evt = 1'b0;
        next_tick_evt = 1'b0;
        flat = {energy, ticks};
        if (clr)
        begin
            next_energy = ENERGY_RST;
            next_ticks = TICK_RST;
        end
        else if (wr)
        begin
            for (int i = 0; i < CNT_BYTES; i++)
                if (wr_idx == 4'(i))
                    flat[(CNT_BYTES-1-i)*8 +: 8] = wr_data;
            {next_energy, next_ticks} = flat;
        end
        else if (conv_done && !halt)
        begin
            {next_energy_evt, next_energy} =
                {1'b0, energy} + (EW+1)'(power);
            next_tick_evt = &ticks;
            next_ticks = ticks + TW'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            energy <= ENERGY_RST;
            ticks <= TICK_RST;
            energy_evt <= 1'b0;
            tick_evt <= 1'b0;
        end
        else
        begin
            energy <= next_energy;
            ticks <= next_ticks;
            energy_evt <= next_energy_evt;
            tick_evt <= next_tick_evt;
        end
    end
endmodule : emar_meter

// >>> hdl/emar_i2c_slave.sv
// Purpose: two-wire serial register port, byte pointer with auto-increment
// Assumes: scl and sda are pins, synchronised here; scl far below core_clk
// Notes: sda is open drain; oe_n low pulls the line low
module emar_i2c_slave
    import emar_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [7:0] rd_data,
    output logic [7:0] rd_ptr,
    output logic wr_stb,
    output emar_wr_s wr
);
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA
    } emar_i2c_e;
    emar_i2c_e st, next_st;
    logic [2:0] scl_sync, sda_sync;
    logic [3:0] bcnt, next_bcnt;
    logic acked, next_acked, nack, next_nack;
    logic [7:0] shift, next_shift, next_ptr;
    logic next_oe_n, next_wr_stb;
    emar_wr_s next_wr;
    logic scl_re, scl_fe, start, stop, sda_bit;

    // stage 0 feeds only stage 1; edges look at stages 1 and 2
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end
        else
        begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
        end
    end

    assign sda_bit = sda_sync[1];
    assign scl_re = scl_sync[1] & ~scl_sync[2];
    assign scl_fe = ~scl_sync[1] & scl_sync[2];
    assign start = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
    assign stop = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

    // bits are taken on scl rise and driven after scl fall
    always_comb
    begin
        next_st = st;
        next_bcnt = bcnt;
        next_acked = acked;
        next_nack = nack;
        next_shift = shift;
        next_ptr = rd_ptr;
        next_oe_n = sda_oe_n;
        next_wr_stb = 1'b0;
        next_wr = wr;
        if (start)
        begin
            next_st = S_ADDR;
            next_bcnt = 4'h0;
            next_acked = 1'b0;
            next_nack = 1'b0;
            next_oe_n = 1'b1;
        end
        else if (stop || st == S_IDLE)
        begin
            next_st = S_IDLE;
            next_oe_n = 1'b1;
        end
        else if (scl_re)
        begin
            if (bcnt == BIT_ACK)
                next_nack = sda_bit;
            else
            begin
                next_bcnt = bcnt + 4'h1;
                if (st != S_RDATA)
                    next_shift = {shift[6:0], sda_bit};
            end
        end
        else if (scl_fe)
        begin
            if (bcnt != BIT_ACK)
            begin
                if (st == S_RDATA)
                begin
                    next_shift = {shift[6:0], 1'b0};
                    next_oe_n = shift[6];
                end
            end
            else if (!acked)
            begin
                next_acked = 1'b1;
                next_oe_n = 1'b0;
                unique case (st)
                    S_IDLE: next_oe_n = 1'b1;
                    S_ADDR:
                        if (shift[7:1] != DEV_ADDR)
                        begin
                            next_st = S_IDLE;
                            next_oe_n = 1'b1;
                        end
                        else if (shift[0])
                            next_st = S_RDATA;
                        else
                            next_st = S_PTR;
                    S_PTR:
                    begin
                        next_ptr = shift;
                        next_st = S_WDATA;
                    end
                    S_WDATA:
                    begin
                        next_wr_stb = 1'b1;
                        next_wr = '{addr: rd_ptr, data: shift};
                        next_ptr = rd_ptr + 8'h01;
                    end
                    S_RDATA: next_oe_n = 1'b1; // host acknowledges
                endcase
            end
            else
            begin
                next_acked = 1'b0;
                next_bcnt = 4'h0;
                next_oe_n = 1'b1;
                if (st == S_RDATA)
                begin
                    if (nack)
                        next_st = S_IDLE;
                    else
                    begin
                        next_shift = rd_data;
                        next_oe_n = rd_data[7];
                        next_ptr = rd_ptr + 8'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= S_IDLE;
            bcnt <= 4'h0;
            acked <= 1'b0;
            nack <= 1'b0;
            shift <= 8'h00;
            rd_ptr <= 8'h00;
            sda_oe_n <= 1'b1;
            sda_out <= 1'b0;
            wr_stb <= 1'b0;
            wr <= '0;
        end
        else
        begin
            st <= next_st;
            bcnt <= next_bcnt;
            acked <= next_acked;
            nack <= next_nack;
            shift <= next_shift;
            rd_ptr <= next_ptr;
            sda_oe_n <= next_oe_n;
            sda_out <= 1'b0;
            wr_stb <= next_wr_stb;
            wr <= next_wr;
        end
    end
endmodule : emar_i2c_slave

// >>> hdl/emar_top.sv
// Purpose: alert masks, meter control, snapshot control and energy meter
// Assumes: alarm logs, conversion pulses and lock status are same-clock
// Notes: register reads are side-effect free; unmapped bytes read 0x00
module emar_top
    import emar_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10,
    parameter int PW = 24
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [7:0] alarm_drain_sense,
    input wire logic [7:0] alarm_differential,
    input wire logic [1:0] ovf_alert_en,
    input wire logic conv_done,
    input wire logic [PW-1:0] conv_power,
    input wire logic nvm_factory_locked,
    output logic alert_out,
    output emar_snap_s snapshot,
    output logic [7:0] mask_drain_sense,
    output logic [7:0] mask_differential
);
    logic wr_stb;
    emar_wr_s wr;
    logic [7:0] rd_ptr, rd_data;
    logic [47:0] energy;
    logic [31:0] ticks;
    logic energy_evt, tick_evt;
    logic mwr, ctl_wr, alert_cond;
    logic [3:0] widx;
    logic [79:0] cnt_bytes;
    logic meter_reset, meter_halt, tick_ovf, energy_ovf, alert_latched;
    logic next_meter_reset, next_meter_halt, next_tick_ovf;
    logic next_energy_ovf, next_alert_latched, next_alert_out;
    logic [7:0] next_mask_ds, next_mask_diff;
    emar_snap_s next_snapshot;

    emar_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .core_clk(core_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rd_data(rd_data),
        .rd_ptr(rd_ptr),
        .wr_stb(wr_stb),
        .wr(wr)
    );

    // counter bytes 0x7A..0x83 form one contiguous window
    assign mwr = wr_stb && wr.addr >= OFS_ENERGY
        && wr.addr < OFS_METER_CTL;
    assign widx = 4'(wr.addr - OFS_ENERGY);
    assign ctl_wr = wr_stb && wr.addr == OFS_METER_CTL;

    emar_meter #(
        .PW(PW)
    ) u_meter (
        .core_clk(core_clk),
        .rst(rst),
        .clr(meter_reset),
        .halt(meter_halt),
        .conv_done(conv_done),
        .power(conv_power),
        .wr(mwr),
        .wr_idx(widx),
        .wr_data(wr.data),
        .energy(energy),
        .ticks(ticks),
        .energy_evt(energy_evt),
        .tick_evt(tick_evt)
    );

    // masked alarms plus enabled overflow flags make an alert
    assign alert_cond = |(alarm_drain_sense & mask_drain_sense)
        | |(alarm_differential & mask_differential)
        | (tick_ovf & ovf_alert_en[1])
        | (energy_ovf & ovf_alert_en[0]);

    // hardware set wins over a host clear in the same cycle
    always_comb
    begin
        next_mask_ds = mask_drain_sense;
        next_mask_diff = mask_differential;
        next_snapshot = snapshot;
        next_meter_reset = meter_reset;
        next_meter_halt = meter_halt;
        next_tick_ovf = tick_ovf;
        next_energy_ovf = energy_ovf;
        next_alert_latched = alert_latched;
        if (wr_stb && wr.addr == OFS_MASK_DS)
            next_mask_ds = wr.data;
        if (wr_stb && wr.addr == OFS_MASK_DIFF)
            next_mask_diff = wr.data;
        if (wr_stb && wr.addr == OFS_SNAPSHOT)
        begin
            next_snapshot.sel = emar_snap_sel_e'(wr.data[7:4]);
            next_snapshot.single = wr.data[SNAP_MODE];
        end
        if (ctl_wr)
        begin
            next_meter_reset = wr.data[MC_RESET];
            next_meter_halt = wr.data[MC_HALT];
            next_tick_ovf = wr.data[MC_TICK_OVF];
            next_energy_ovf = wr.data[MC_ENERGY_OVF];
            next_alert_latched = wr.data[MC_ALERT];
        end
        if (tick_evt)
            next_tick_ovf = 1'b1;
        if (energy_evt)
            next_energy_ovf = 1'b1;
        if (alert_cond)
            next_alert_latched = 1'b1;
        next_alert_out = alert_cond;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mask_drain_sense <= MASK_RST;
            mask_differential <= MASK_RST;
            snapshot <= '0;
            meter_reset <= 1'b0;
            meter_halt <= 1'b0;
            tick_ovf <= 1'b0;
            energy_ovf <= 1'b0;
            alert_latched <= 1'b0;
            alert_out <= 1'b0;
        end
        else
        begin
            mask_drain_sense <= next_mask_ds;
            mask_differential <= next_mask_diff;
            snapshot <= next_snapshot;
            meter_reset <= next_meter_reset;
            meter_halt <= next_meter_halt;
            tick_ovf <= next_tick_ovf;
            energy_ovf <= next_energy_ovf;
            alert_latched <= next_alert_latched;
            alert_out <= next_alert_out;
        end
    end

    // read mux; reserved bits are forced to zero
    assign cnt_bytes = {energy, ticks};
    always_comb
    begin
        rd_data = 8'h00;
        for (int i = 0; i < CNT_BYTES; i++)
            if (rd_ptr == OFS_ENERGY + 8'(i))
                rd_data = cnt_bytes[(CNT_BYTES-1-i)*8 +: 8];
        case (rd_ptr)
            OFS_MASK_DS: rd_data = mask_drain_sense;
            OFS_MASK_DIFF: rd_data = mask_differential;
            OFS_METER_CTL:
                rd_data = {meter_reset, meter_halt, tick_ovf,
                    energy_ovf, alert_latched,
                    nvm_factory_locked, 2'b00};
            OFS_SNAPSHOT:
                rd_data = {snapshot.sel, snapshot.single,
                    3'b000};
            default: ;
        endcase
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_conv_go;
        conv_done && !meter_reset && !meter_halt && !mwr;
    endsequence

    sequence s_ctl_quiet;
        !ctl_wr;
    endsequence

    a_reset_holds: assert property (
        meter_reset |=> energy == ENERGY_RST && ticks == TICK_RST)
        else $error("meter reset did not clear counters");

    a_halt_freezes: assert property (
        meter_halt && !meter_reset && !mwr
        |=> $stable(energy) && $stable(ticks))
        else $error("halted meter changed");

    a_tick_counts: assert property (
        s_conv_go |=> ticks == $past(ticks) + 32'h1)
        else $error("tick counter did not advance");

    a_energy_adds: assert property (
        s_conv_go |=> energy ==
            48'($past(energy) + 48'($past(conv_power))))
        else $error("energy did not accumulate power");

    a_tick_ovf_flag: assert property (
        s_conv_go ##0 (&ticks) |=> tick_evt ##1 tick_ovf)
        else $error("tick overflow not flagged");

    a_energy_ovf_flag: assert property (
        energy_evt |=> energy_ovf)
        else $error("energy overflow not flagged");

    a_alert_latch: assert property (
        alert_cond |=> alert_latched && alert_out)
        else $error("alert not latched");

    a_alert_sticky: assert property (
        alert_latched ##0 s_ctl_quiet |=> alert_latched)
        else $error("alert flag cleared without host write");

    a_alert_quiet: assert property (
        !alert_cond |=> !alert_out)
        else $error("alert output without enabled alarm");

    a_lock_report: assert property (
        rd_ptr == OFS_METER_CTL |-> rd_data[2] == nvm_factory_locked)
        else $error("lock status misreported");

    a_reserved_zero: assert property (
        (rd_ptr == OFS_METER_CTL |-> rd_data[1:0] == 2'b00)
        and (rd_ptr == OFS_SNAPSHOT |-> rd_data[2:0] == 3'b000))
        else $error("reserved bits read nonzero");

    a_mask_write: assert property (
        wr_stb && wr.addr == OFS_MASK_DS
        |=> mask_drain_sense == $past(wr.data))
        else $error("drain/sense mask not written");

    a_diff_mask_write: assert property (
        wr_stb && wr.addr == OFS_MASK_DIFF
        |=> mask_differential == $past(wr.data))
        else $error("differential mask not written");

    a_snap_write: assert property (
        wr_stb && wr.addr == OFS_SNAPSHOT
        |=> snapshot == {$past(wr.data[7:4]), $past(wr.data[3])})
        else $error("snapshot control not written");

    // overflow flags stick until the host rewrites meter control
    a_tick_ovf_sticky: assert property (
        tick_ovf && !ctl_wr |=> tick_ovf)
        else $error("tick overflow flag lost");

    a_energy_ovf_sticky: assert property (
        energy_ovf && !ctl_wr |=> energy_ovf)
        else $error("energy overflow flag lost");

    a_tick_wraps: assert property (
        tick_evt |-> ticks == TICK_RST)
        else $error("tick overflow without wrap");

    a_evt_needs_conv: assert property (
        !conv_done |=> !tick_evt && !energy_evt)
        else $error("overflow event without conversion");

    a_tick_ovf_alert: assert property (
        tick_ovf && ovf_alert_en[1] |=> alert_out)
        else $error("enabled tick overflow gave no alert");

    a_energy_ovf_alert: assert property (
        energy_ovf && ovf_alert_en[0] |=> alert_out)
        else $error("enabled energy overflow gave no alert");

    a_ds_alarm_gate: assert property (
        |(alarm_drain_sense & mask_drain_sense) |=> alert_out)
        else $error("enabled drain/sense alarm gave no alert");

    a_diff_alarm_gate: assert property (
        |(alarm_differential & mask_differential) |=> alert_out)
        else $error("enabled differential alarm gave no alert");

    a_alert_clear: assert property (
        ctl_wr && !wr.data[MC_ALERT] && !alert_cond |=> !alert_latched)
        else $error("host write did not clear alert flag");

    a_reset_write: assert property (
        ctl_wr |=> meter_reset == $past(wr.data[MC_RESET]))
        else $error("meter reset bit not written");

    a_halt_write: assert property (
        ctl_wr |=> meter_halt == $past(wr.data[MC_HALT]))
        else $error("meter halt bit not written");

    // read map: the host sees what the registers hold
    a_mask_read: assert property (
        rd_ptr == OFS_MASK_DS |-> rd_data == mask_drain_sense)
        else $error("drain/sense mask misread");

    a_snap_read: assert property (
        rd_ptr == OFS_SNAPSHOT |-> rd_data[7:4] == snapshot.sel)
        else $error("snapshot select misread");

    a_energy_read: assert property (
        rd_ptr == OFS_ENERGY |-> rd_data == energy[47:40])
        else $error("energy high byte misread");

    a_tick_read: assert property (
        rd_ptr == OFS_TICK |-> rd_data == ticks[31:24])
        else $error("tick high byte misread");
endmodule : emar_top

// >>> test/emar_host.sv
// Purpose: two-wire host model that reaches the register space
// Assumes: phases of 5 core_clk, above the 4-cycle minimum
// Notes: sda has a pull-up, so a released line reads 1
module emar_host
    import emar_pkg::*;
#(
    parameter logic [6:0] DEV = 7'h10
)
(
    input wire logic core_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus: both lines released
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // one phase, always ending just after a clock edge
    task automatic hp;
        repeat (5) @(posedge core_clk);
        #5;
    endtask : hp

    // sda moves a phase after scl falls, never while scl is high
    task automatic bit_x(input logic b, output logic r);
        sda = b;
        hp;
        scl = 1'b1;
        hp;
        r = sda_wire;
        scl = 1'b0;
        hp;
    endtask : bit_x

    // ak = 1 releases the ninth bit, ok tells whether it was pulled low
    task automatic byte_x(input logic [7:0] d, input logic ak,
                          output logic [7:0] r, output logic ok);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], b);
            r[i] = b;
        end
        bit_x(ak, b);
        ok = !b;
    endtask : byte_x

    // start and repeated start share one sequence
    task automatic start;
        sda = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda = 1'b0;
        hp;
        scl = 1'b0;
        hp;
    endtask : start

    task automatic stop;
        sda = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda = 1'b1;
        hp;
    endtask : stop

    task automatic adr(input logic [7:0] a, output logic ok);
        logic [7:0] r;
        start;
        byte_x(a, 1'b1, r, ok);
    endtask : adr

    // flags are cleared only by such a byte write
    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] r;
        logic k1;
        logic k2;
        adr({DEV, 1'b0}, ok);
        byte_x(p, 1'b1, r, k1);
        byte_x(d, 1'b1, r, k2);
        stop;
        ok = ok & k1 & k2;
    endtask : wr

    // single byte read, ended by a host nack
    task automatic rd(input logic [7:0] p, output logic [7:0] d,
                      output logic ok);
        logic [7:0] r;
        logic k1;
        logic k2;
        adr({DEV, 1'b0}, ok);
        byte_x(p, 1'b1, r, k1);
        adr({DEV, 1'b1}, k2);
        byte_x(8'hFF, 1'b1, d, r[0]);
        stop;
        ok = ok & k1 & k2;
    endtask : rd
endmodule : emar_host

// >>> test/tb.sv
// Purpose: self-checking bench of the meter and alert registers
// Assumes: register access only through the two-wire host model
// Notes: the counters are driven to wrap by direct byte writes
module tb
    import emar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic h_scl;
    logic h_sda;
    logic sda_out;
    logic sda_oe_n;
    logic sda_w;
    logic alert_out;
    logic [7:0] al_ds = 8'h00;
    logic [7:0] al_df = 8'h00;
    logic [7:0] mask_ds;
    logic [7:0] mask_df;
    logic [1:0] ovf_en = 2'b00;
    logic conv = 1'b0;
    logic [23:0] pwr = 24'h000000;
    logic lock = 1'b0;
    emar_snap_s snap;
    int n_mismatch = 0;
    int n_tests = 0;

    always #25 core_clk = ~core_clk;

    // open drain wire: either party may pull it low
    assign sda_w = h_sda & (sda_oe_n | sda_out);

    emar_top dut (
        .core_clk(core_clk),
        .rst(rst),
        .scl_in(h_scl),
        .sda_in(sda_w),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .alarm_drain_sense(al_ds),
        .alarm_differential(al_df),
        .ovf_alert_en(ovf_en),
        .conv_done(conv),
        .conv_power(pwr),
        .nvm_factory_locked(lock),
        .alert_out(alert_out),
        .snapshot(snap),
        .mask_drain_sense(mask_ds),
        .mask_differential(mask_df)
    );

    emar_host #(.DEV(7'h10)) h (
        .core_clk(core_clk),
        .sda_wire(sda_w),
        .scl(h_scl),
        .sda(h_sda)
    );

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask : cyc

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        h.rd(a, d, ok);
        chk({ok, d}, {1'b1, e});
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        h.wr(a, d, ok);
        chk(ok, 1'b1);
    endtask : wr

    // one-cycle conversion pulse carrying a power result
    task automatic pulse(input logic [23:0] p);
        conv = 1'b1;
        pwr = p;
        cyc(1);
        conv = 1'b0;
        cyc(2);
    endtask : pulse

    task automatic t_reset;
        for (int a = 8'h7A; a <= 8'h85; a++)
        begin
            rd_chk(a[7:0], 8'h00);
        end
        rd_chk(8'h30, 8'h00);
        chk({mask_ds, mask_df, snap}, 21'h0);
    endtask : t_reset

    // disjoint alarm and mask bits must stay quiet
    task automatic t_masks;
        logic ok;
        wr(8'h19, 8'hA5);
        wr(8'h1A, 8'h3C);
        chk({mask_ds, mask_df}, 16'hA53C);
        rd_chk(8'h1A, 8'h3C);
        al_ds = 8'h5A;
        al_df = 8'hC3;
        cyc(3);
        chk(alert_out, 1'b0);
        al_df = 8'h04;
        cyc(3);
        chk(alert_out, 1'b1);
        al_df = 8'h00;
        al_ds = 8'h80;
        cyc(3);
        chk(alert_out, 1'b1);
        al_ds = 8'h00;
        cyc(3);
        chk(alert_out, 1'b0);
        rd_chk(8'h84, 8'h08);
        wr(8'h84, 8'h00);
        rd_chk(8'h84, 8'h00);
        // a foreign device address is refused and changes nothing
        h.adr(8'h42, ok);
        h.stop;
        chk(ok, 1'b0);
        rd_chk(8'h19, 8'hA5);
    endtask : t_masks

    // every selector code, reserved bits written as ones
    task automatic t_snap;
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h85, {c[3:0], 4'hF});
            chk(snap, {c[3:0], 1'b1});
            rd_chk(8'h85, {c[3:0], 4'h8});
        end
        wr(8'h85, 8'h57);
        chk(snap, 5'h0A);
    endtask : t_snap

    task automatic t_meter;
        pulse(24'h000003);
        pulse(24'h000005);
        rd_chk(8'h7F, 8'h08);
        rd_chk(8'h83, 8'h02);
        wr(8'h84, 8'h40);
        pulse(24'h000009);
        rd_chk(8'h7F, 8'h08);
        rd_chk(8'h83, 8'h02);
        wr(8'h84, 8'h80);
        pulse(24'h000009);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h83, 8'h00);
        wr(8'h84, 8'h00);
        for (int a = 8'h7A; a <= 8'h83; a++)
        begin
            wr(a[7:0], 8'hFF);
        end
        rd_chk(8'h7C, 8'hFF);
        pulse(24'h000001);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h84, 8'h30);
        chk(alert_out, 1'b0);
        ovf_en = 2'b01;
        cyc(3);
        chk(alert_out, 1'b1);
        ovf_en = 2'b10;
        cyc(3);
        chk(alert_out, 1'b1);
        ovf_en = 2'b00;
        cyc(3);
        rd_chk(8'h84, 8'h38);
        lock = 1'b1;
        wr(8'h84, 8'h03);
        rd_chk(8'h84, 8'h04);
        // one overflow flag at a time tells the two enables apart
        wr(8'h84, 8'h20);
        ovf_en = 2'b01;
        cyc(3);
        chk(alert_out, 1'b0);
        ovf_en = 2'b10;
        cyc(3);
        chk(alert_out, 1'b1);
        ovf_en = 2'b00;
    endtask : t_meter

    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    initial
    begin
        repeat (4) @(posedge core_clk);
        #5;
        rst = 1'b0;
        cyc(4);
        t_reset;
        t_masks;
        t_snap;
        t_meter;
        close_out;
    end

    // the whole run needs about 42k cycles; a hang is cut off here
    initial
    begin
        repeat (90000) @(posedge core_clk);
        n_mismatch++;
        close_out;
    end
endmodule : tb
